// >>> shared/tpcs_pkg.sv
// Purpose: shared constants and types of the timer prescaler clock select block
// Assumes: 4-bit data bus, 16-bit addresses, byte-wide register map
// Notes: one register per address, data in the low four bits
package tpcs_pkg;
  localparam int DATA_W = 4;
  localparam int ADDR_W = 16;
  localparam int PSC_W = 8;

  // register addresses
  localparam logic [15:0] ADDR_T0_MODE = 16'hffc0;
  localparam logic [15:0] ADDR_CLK_SRC = 16'hffc1;
  localparam logic [15:0] ADDR_T0_CTRL = 16'hffc2;
  localparam logic [15:0] ADDR_T1_CTRL = 16'hffc3;
  localparam logic [15:0] ADDR_IRQ_FLAGS = 16'hfff2;

  // mode register fields
  localparam int BIT_POLARITY = 0;
  localparam int BIT_NOISE_REJ = 1;
  localparam int BIT_EVENT_MODE = 2;
  // clock source register fields
  localparam int BIT_T0_SRC = 0;
  localparam int BIT_T1_SRC = 1;
  localparam int BIT_TONE_EN = 2;
  localparam int BIT_TONE_CH = 3;
  // timer control register fields
  localparam int BIT_RUN = 0;
  localparam int BIT_RELOAD = 1;
  localparam int BIT_RATIO_LO = 2;
  localparam int BIT_RATIO_HI = 3;
  // flag register fields
  localparam int BIT_T0_FLAG = 0;
  localparam int BIT_T1_FLAG = 1;

  // ratio codes and the matching divider masks
  localparam logic [1:0] RATIO_DIV1 = 2'h0;
  localparam logic [1:0] RATIO_DIV4 = 2'h1;
  localparam logic [1:0] RATIO_DIV32 = 2'h2;
  localparam logic [1:0] RATIO_DIV256 = 2'h3;
  localparam logic [7:0] MASK_DIV1 = 8'h00;
  localparam logic [7:0] MASK_DIV4 = 8'h03;
  localparam logic [7:0] MASK_DIV32 = 8'h1f;
  localparam logic [7:0] MASK_DIV256 = 8'hff;

  // reset values
  localparam logic RST_BIT = 1'b0;
  localparam logic [1:0] RST_RATIO = 2'h0;
  localparam logic [7:0] RST_PSC = 8'h00;
  localparam logic [3:0] RST_DATA = 4'h0;

  typedef struct packed {
    logic [15:0] addr;
    logic [3:0] wdata;
    logic wr;
    logic rd;
  } tpcs_bus_req_t;

  typedef struct packed {
    logic run;
    logic [1:0] ratio;
  } tpcs_tmr_cfg_t;
endpackage

// >>> rtl/tpcs_top.sv
// Purpose: clock source and prescaler ratio select for two down-counting timers, plus
//          their interrupt factor flags
// Assumes: oscillator clocks, underflows and event ticks are synchronous to ref_clk_in
// Notes: count enables are one-cycle strobes for the counters that sit outside
`timescale 1ns/100ps

// Summary of operation
// - each timer flag sets on interrupt, clears on writing 1, ignores 0, resets 0
// - upper two bits of the flag register read zero and hold no storage
// - timer 0 source bit: 0 first oscillator, 1 second; readable; resets 0
// - timer 1 has its own source bit, same coding, readback and reset
// - in event counter mode the timer 0 source bit is ignored
// - ratio 11 divides by 256, 10 by 32, 01 by 4, 00 by 1; resets 00
// - ratio bits sit at bits 2 and 3 of each timer control register
// - in event counter mode the timer 0 ratio field is ignored
// - timer 0 mode bit: 1 event counter, 0 timer; resets to timer mode
// - underflow sets its flag even while that interrupt is masked
module tpcs_top (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire tpcs_pkg::tpcs_bus_req_t bus_req_in,
  output logic [3:0] bus_rdata_out,
  input wire logic first_oscillator_clock_in,
  input wire logic second_oscillator_clock_in,
  input wire logic t0_event_tick_in,
  input wire logic t0_underflow_in,
  input wire logic t1_underflow_in,
  output logic t0_count_en_out,
  output logic t1_count_en_out,
  output logic t0_event_mode_sel_out,
  output logic t0_noise_rej_out,
  output logic t0_rising_edge_out,
  output logic tone_enable_out,
  output logic tone_channel_out,
  output logic t0_run_out,
  output logic t1_run_out,
  output logic t0_reload_out,
  output logic t1_reload_out,
  output logic t0_irq_flag_out,
  output logic t1_irq_flag_out
);
  import tpcs_pkg::*;

  function automatic logic [7:0] ratio_mask(input logic [1:0] ratio);
    logic [7:0] m;
    m = MASK_DIV1;
    case (ratio)
      RATIO_DIV4: m = MASK_DIV4;
      RATIO_DIV32: m = MASK_DIV32;
      RATIO_DIV256: m = MASK_DIV256;
      default: m = MASK_DIV1;
    endcase
    return m;
  endfunction

  function automatic logic hit(input tpcs_bus_req_t req, input logic [15:0] addr);
    return req.wr && (req.addr == addr);
  endfunction

  // register state
  logic evt_q, evt_d;
  logic nrej_q, nrej_d;
  logic pol_q, pol_d;
  logic src0_q, src0_d;
  logic src1_q, src1_d;
  logic tone_en_q, tone_en_d;
  logic tone_ch_q, tone_ch_d;
  tpcs_tmr_cfg_t cfg0_q, cfg0_d;
  tpcs_tmr_cfg_t cfg1_q, cfg1_d;
  logic rld0_q, rld0_d;
  logic rld1_q, rld1_d;
  logic flag0_q, flag0_d;
  logic flag1_q, flag1_d;
  logic [3:0] rdata_q, rdata_d;

  // prescaler state
  logic first_osc_prev_q, second_osc_prev_q;
  logic [7:0] psc0_q, psc0_d;
  logic [7:0] psc1_q, psc1_d;
  logic cen0_q, cen0_d;
  logic cen1_q, cen1_d;
  logic tick0, tick1, rise1, rise3;

  always_comb begin
    evt_d = evt_q;
    nrej_d = nrej_q;
    pol_d = pol_q;
    src0_d = src0_q;
    src1_d = src1_q;
    tone_en_d = tone_en_q;
    tone_ch_d = tone_ch_q;
    cfg0_d = cfg0_q;
    cfg1_d = cfg1_q;
    rld0_d = 1'b0;
    rld1_d = 1'b0;
    rdata_d = RST_DATA;
    if (hit(bus_req_in, ADDR_T0_MODE)) begin
      evt_d = bus_req_in.wdata[BIT_EVENT_MODE];
      nrej_d = bus_req_in.wdata[BIT_NOISE_REJ];
      pol_d = bus_req_in.wdata[BIT_POLARITY];
    end else if (hit(bus_req_in, ADDR_CLK_SRC)) begin
      src0_d = bus_req_in.wdata[BIT_T0_SRC];
      src1_d = bus_req_in.wdata[BIT_T1_SRC];
      tone_en_d = bus_req_in.wdata[BIT_TONE_EN];
      tone_ch_d = bus_req_in.wdata[BIT_TONE_CH];
    end else if (hit(bus_req_in, ADDR_T0_CTRL)) begin
      cfg0_d.run = bus_req_in.wdata[BIT_RUN];
      cfg0_d.ratio = bus_req_in.wdata[BIT_RATIO_HI:BIT_RATIO_LO];
      rld0_d = bus_req_in.wdata[BIT_RELOAD];
    end else if (hit(bus_req_in, ADDR_T1_CTRL)) begin
      cfg1_d.run = bus_req_in.wdata[BIT_RUN];
      cfg1_d.ratio = bus_req_in.wdata[BIT_RATIO_HI:BIT_RATIO_LO];
      rld1_d = bus_req_in.wdata[BIT_RELOAD];
    end
    // unmapped reads answer zero; reload bits always read zero
    if (bus_req_in.rd) begin
      if (bus_req_in.addr == ADDR_T0_MODE) begin
        rdata_d[BIT_EVENT_MODE] = evt_q;
        rdata_d[BIT_NOISE_REJ] = nrej_q;
        rdata_d[BIT_POLARITY] = pol_q;
      end else if (bus_req_in.addr == ADDR_CLK_SRC) begin
        rdata_d = {tone_ch_q, tone_en_q, src1_q, src0_q};
      end else if (bus_req_in.addr == ADDR_T0_CTRL) begin
        rdata_d = {cfg0_q.ratio, 1'b0, cfg0_q.run};
      end else if (bus_req_in.addr == ADDR_T1_CTRL) begin
        rdata_d = {cfg1_q.ratio, 1'b0, cfg1_q.run};
      end else if (bus_req_in.addr == ADDR_IRQ_FLAGS) begin
        rdata_d = {2'h0, flag1_q, flag0_q};
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      evt_q <= RST_BIT;
      nrej_q <= RST_BIT;
      pol_q <= RST_BIT;
      src0_q <= RST_BIT;
      src1_q <= RST_BIT;
      tone_en_q <= RST_BIT;
      tone_ch_q <= RST_BIT;
      cfg0_q <= '{run: RST_BIT, ratio: RST_RATIO};
      cfg1_q <= '{run: RST_BIT, ratio: RST_RATIO};
      rld0_q <= RST_BIT;
      rld1_q <= RST_BIT;
      rdata_q <= RST_DATA;
    end else if (ce_in) begin
      evt_q <= evt_d;
      nrej_q <= nrej_d;
      pol_q <= pol_d;
      src0_q <= src0_d;
      src1_q <= src1_d;
      tone_en_q <= tone_en_d;
      tone_ch_q <= tone_ch_d;
      cfg0_q <= cfg0_d;
      cfg1_q <= cfg1_d;
      rld0_q <= rld0_d;
      rld1_q <= rld1_d;
      rdata_q <= rdata_d;
    end
  end

  // interrupt factor flags: a set in the clearing cycle wins, so no underflow is lost
  always_comb begin
    flag0_d = flag0_q;
    flag1_d = flag1_q;
    if (hit(bus_req_in, ADDR_IRQ_FLAGS)) begin
      if (bus_req_in.wdata[BIT_T0_FLAG]) flag0_d = 1'b0;
      if (bus_req_in.wdata[BIT_T1_FLAG]) flag1_d = 1'b0;
    end
    // masking lives elsewhere and never gates the set
    if (t0_underflow_in) flag0_d = 1'b1;
    if (t1_underflow_in) flag1_d = 1'b1;
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      flag0_q <= RST_BIT;
      flag1_q <= RST_BIT;
    end else if (ce_in) begin
      flag0_q <= flag0_d;
      flag1_q <= flag1_d;
    end
  end

  // source clocks are sampled levels; a rising edge is one source period
  assign rise1 = first_oscillator_clock_in && !first_osc_prev_q;
  assign rise3 = second_oscillator_clock_in && !second_osc_prev_q;
  assign tick0 = src0_q ? rise3 : rise1;
  assign tick1 = src1_q ? rise3 : rise1;

  always_comb begin
    psc0_d = psc0_q;
    psc1_d = psc1_q;
    cen0_d = 1'b0;
    cen1_d = 1'b0;
    if (evt_q) begin
      // event counting bypasses source select and divider alike
      psc0_d = RST_PSC;
      cen0_d = cfg0_q.run && t0_event_tick_in;
    end else if (tick0) begin
      psc0_d = psc0_q + 8'h01;
      cen0_d = cfg0_q.run && ((psc0_q & ratio_mask(cfg0_q.ratio)) ==
        ratio_mask(cfg0_q.ratio));
    end
    if (tick1) begin
      psc1_d = psc1_q + 8'h01;
      cen1_d = cfg1_q.run && ((psc1_q & ratio_mask(cfg1_q.ratio)) ==
        ratio_mask(cfg1_q.ratio));
    end
    // a reload restarts the division so the first period is whole
    if (rld0_q) psc0_d = RST_PSC;
    if (rld1_q) psc1_d = RST_PSC;
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      first_osc_prev_q <= RST_BIT;
      second_osc_prev_q <= RST_BIT;
      psc0_q <= RST_PSC;
      psc1_q <= RST_PSC;
      cen0_q <= RST_BIT;
      cen1_q <= RST_BIT;
    end else if (ce_in) begin
      first_osc_prev_q <= first_oscillator_clock_in;
      second_osc_prev_q <= second_oscillator_clock_in;
      psc0_q <= psc0_d;
      psc1_q <= psc1_d;
      cen0_q <= cen0_d;
      cen1_q <= cen1_d;
    end
  end

  assign bus_rdata_out = rdata_q;
  assign t0_count_en_out = cen0_q && ce_in;
  assign t1_count_en_out = cen1_q && ce_in;
  assign t0_event_mode_sel_out = evt_q;
  assign t0_noise_rej_out = nrej_q;
  assign t0_rising_edge_out = pol_q;
  assign tone_enable_out = tone_en_q;
  assign tone_channel_out = tone_ch_q;
  assign t0_run_out = cfg0_q.run;
  assign t1_run_out = cfg1_q.run;
  assign t0_reload_out = rld0_q && ce_in;
  assign t1_reload_out = rld1_q && ce_in;
  assign t0_irq_flag_out = flag0_q;
  assign t1_irq_flag_out = flag1_q;

  chk_flag_sets: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (ce_in && t0_underflow_in) |=> t0_irq_flag_out)
    else $error("timer 0 flag missed an underflow");

  chk_flag_clears: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (ce_in && hit(bus_req_in, ADDR_IRQ_FLAGS) && bus_req_in.wdata[BIT_T1_FLAG]
      && !t1_underflow_in) |=> !t1_irq_flag_out)
    else $error("timer 1 flag not cleared by a one");

  chk_flag_zero_write: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (hit(bus_req_in, ADDR_IRQ_FLAGS) && !bus_req_in.wdata[BIT_T0_FLAG] && t0_irq_flag_out)
      |=> t0_irq_flag_out)
    else $error("writing zero disturbed timer 0 flag");

  chk_flag_upper_zero: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (ce_in && bus_req_in.rd && bus_req_in.addr == ADDR_IRQ_FLAGS)
      |=> bus_rdata_out[3:2] == 2'h0)
    else $error("unused flag bits read nonzero");

  chk_src_readback: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (ce_in && bus_req_in.rd && bus_req_in.addr == ADDR_CLK_SRC)
      |=> bus_rdata_out[BIT_T0_SRC] == $past(src0_q))
    else $error("timer 0 source bit reads back wrong");

  chk_t1_src_write: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (ce_in && hit(bus_req_in, ADDR_CLK_SRC))
      |=> src1_q == $past(bus_req_in.wdata[BIT_T1_SRC]))
    else $error("timer 1 source bit not stored");

  chk_ratio_field: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (ce_in && hit(bus_req_in, ADDR_T0_CTRL))
      |=> cfg0_q.ratio == $past(bus_req_in.wdata[BIT_RATIO_HI:BIT_RATIO_LO]))
    else $error("timer 0 ratio field not at bits 3:2");

  chk_event_bypass: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (ce_in && evt_q && cfg0_q.run && t0_event_tick_in) ##1 ce_in |-> t0_count_en_out)
    else $error("event mode did not pass the event tick");

  chk_div_by_one: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (ce_in && !evt_q && cfg1_q.run && cfg1_q.ratio == RATIO_DIV1 && tick1)
      ##1 ce_in |-> t1_count_en_out)
    else $error("divide by one dropped a source tick");

  chk_enable_single: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (ce_in && t1_count_en_out) ##1 ce_in |-> !t1_count_en_out)
    else $error("count enable longer than one cycle");

  chk_mode_reset: assert property (
    @(posedge ref_clk_in) !rst_n_in |=> !t0_event_mode_sel_out)
    else $error("reset left event counter mode selected");

  chk_flag_reset: assert property (
    @(posedge ref_clk_in) !rst_n_in |=> !t0_irq_flag_out && !t1_irq_flag_out)
    else $error("reset left an interrupt flag set");

  chk_src_reset: assert property (
    @(posedge ref_clk_in) !rst_n_in |=> !src0_q && !src1_q)
    else $error("reset left the second oscillator selected");

  chk_ratio_reset: assert property (
    @(posedge ref_clk_in) !rst_n_in
      |=> cfg0_q.ratio == RST_RATIO && cfg1_q.ratio == RST_RATIO)
    else $error("reset left a ratio field nonzero");

  chk_t0_flag_clear: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (ce_in && hit(bus_req_in, ADDR_IRQ_FLAGS) && bus_req_in.wdata[BIT_T0_FLAG]
      && !t0_underflow_in) |=> !t0_irq_flag_out)
    else $error("timer 0 flag not cleared by a one");

  chk_t1_flag_sets: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (ce_in && t1_underflow_in) |=> t1_irq_flag_out)
    else $error("timer 1 flag missed an underflow");

  chk_event_only: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (ce_in && evt_q && !t0_event_tick_in) ##1 ce_in |-> !t0_count_en_out)
    else $error("event mode passed a source clock tick");

  chk_t1_ratio_field: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (ce_in && hit(bus_req_in, ADDR_T1_CTRL))
      |=> cfg1_q.ratio == $past(bus_req_in.wdata[BIT_RATIO_HI:BIT_RATIO_LO]))
    else $error("timer 1 ratio field not at bits 3:2");
endmodule

// >>> rtl/tpcs_top_dummy_removed.sv
// Purpose: reserved for leaf cells of the timer prescaler clock select block
// Assumes: all logic lives in tpcs_top
// Notes: left without a module so that only one design module elaborates

// >>> testbench/tb_timer_prescaler_clock_select.sv
// Purpose: self-checking bench for the timer prescaler clock select block
// Assumes: ce_in high except in the hold test; oscillator levels move in step with ref_clk_in
// Notes: count enables are totted up by a monitor, so a stuck-high pulse doubles the count
`timescale 1ns/100ps
module tb_timer_prescaler_clock_select;
  import tpcs_pkg::*;
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  tpcs_bus_req_t req = '0;
  logic [3:0] rdata;
  logic src_a = 1'b0;
  logic src_b = 1'b0;
  logic ce = 1'b1;
  logic [7:0] misc;
  logic ev = 1'b0;
  logic uf0 = 1'b0;
  logic uf1 = 1'b0;
  logic en0, en1, evsel, fl0, fl1;
  int fail_count = 0;
  int checks = 0;
  int n0 = 0;
  int n1 = 0;

  tpcs_top i_tpcs_top (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .ce_in(ce),
    .bus_req_in(req), .bus_rdata_out(rdata), .first_oscillator_clock_in(src_a),
    .second_oscillator_clock_in(src_b), .t0_event_tick_in(ev), .t0_underflow_in(uf0),
    .t1_underflow_in(uf1), .t0_count_en_out(en0), .t1_count_en_out(en1),
    .t0_event_mode_sel_out(evsel), .t0_noise_rej_out(misc[0]), .t0_rising_edge_out(misc[1]),
    .tone_enable_out(misc[2]), .tone_channel_out(misc[3]), .t0_run_out(misc[4]),
    .t1_run_out(misc[5]), .t0_reload_out(misc[6]), .t1_reload_out(misc[7]),
    .t0_irq_flag_out(fl0), .t1_irq_flag_out(fl1));

  initial begin
    forever #2 ref_clk_in = ~ref_clk_in;
  end

  always @(posedge ref_clk_in) begin
    if (en0 === 1'b1) n0 <= n0 + 1;
    if (en1 === 1'b1) n1 <= n1 + 1;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [15:0] a, input logic [3:0] d);
    @(posedge ref_clk_in);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk_in);
    req <= '0;
  endtask

  // read data stands only in the cycle after the strobe, so sample just past that edge
  task automatic rd_chk(input logic [15:0] a, input logic [3:0] exp);
    @(posedge ref_clk_in);
    req <= '{addr: a, wdata: 4'h0, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk_in);
    req <= '0;
    #1 chk(16'(rdata), 16'(exp));
  endtask

  // one-cycle high on the chosen line: 0/1 oscillators, 2 event, 3/4 underflows
  task automatic pulse(input int which);
    @(posedge ref_clk_in);
    case (which)
      0: src_a <= 1'b1;
      1: src_b <= 1'b1;
      2: ev <= 1'b1;
      3: uf0 <= 1'b1;
      default: uf1 <= 1'b1;
    endcase
    @(posedge ref_clk_in);
    {src_a, src_b, ev, uf0, uf1} <= 5'h00;
  endtask

  function automatic int cnt(input int t);
    return (t == 0) ? n0 : n1;
  endfunction

  task automatic test_reset();
    rd_chk(ADDR_T0_MODE, 4'h0);
    rd_chk(ADDR_CLK_SRC, 4'h0);
    rd_chk(ADDR_T0_CTRL, 4'h0);
    rd_chk(ADDR_T1_CTRL, 4'h0);
    rd_chk(ADDR_IRQ_FLAGS, 4'h0);
    rd_chk(16'hffc4, 4'h0);
    $display("test reset values done");
  endtask

  task automatic test_flags();
    pulse(3);
    rd_chk(ADDR_IRQ_FLAGS, 4'h1);
    wr(ADDR_IRQ_FLAGS, 4'h0);
    rd_chk(ADDR_IRQ_FLAGS, 4'h1);
    wr(ADDR_IRQ_FLAGS, 4'h1);
    rd_chk(ADDR_IRQ_FLAGS, 4'h0);
    pulse(4);
    pulse(3);
    #1 chk(16'({fl1, fl0}), 16'h0003);
    wr(ADDR_IRQ_FLAGS, 4'hd);
    rd_chk(ADDR_IRQ_FLAGS, 4'h2);
    wr(ADDR_IRQ_FLAGS, 4'hf);
    rd_chk(ADDR_IRQ_FLAGS, 4'h0);
    $display("test flags done");
  endtask

  // a reload write clears the divider, so 512 ticks give exactly 512 / ratio enables
  task automatic run_ratio(input int t, input logic [1:0] r, input int src);
    logic [15:0] ca;
    int b;
    int sh;
    ca = (t == 0) ? ADDR_T0_CTRL : ADDR_T1_CTRL;
    sh = (r == 2'h0) ? 0 : (r == 2'h1) ? 2 : (r == 2'h2) ? 5 : 8;
    wr(ADDR_CLK_SRC, 4'(src << t));
    rd_chk(ADDR_CLK_SRC, 4'(src << t));
    wr(ca, {r, 2'b11});
    rd_chk(ca, {r, 2'b01});
    b = cnt(t);
    repeat (512) pulse(src);
    repeat (3) @(posedge ref_clk_in);
    chk(16'(cnt(t) - b), 16'(512 >> sh));
    b = cnt(t);
    repeat (64) pulse(1 - src);
    repeat (3) @(posedge ref_clk_in);
    chk(16'(cnt(t) - b), 16'h0000);
    wr(ca, 4'h0);
    $display("test ratio t=%0d r=%0d src=%0d done", t, r, src);
  endtask

  task automatic test_event();
    int b;
    wr(ADDR_T0_MODE, 4'h4);
    rd_chk(ADDR_T0_MODE, 4'h4);
    chk(16'(evsel), 16'h0001);
    wr(ADDR_CLK_SRC, 4'h1);
    wr(ADDR_T0_CTRL, 4'hf);
    b = n0;
    repeat (10) pulse(2);
    repeat (3) @(posedge ref_clk_in);
    chk(16'(n0 - b), 16'h000a);
    // ratio /1 with the second source stored: any leak of a source tick would count
    wr(ADDR_T0_CTRL, 4'h1);
    b = n0;
    repeat (20) pulse(1);
    repeat (20) pulse(0);
    repeat (3) @(posedge ref_clk_in);
    chk(16'(n0 - b), 16'h0000);
    wr(ADDR_T0_CTRL, 4'h0);
    wr(ADDR_T0_MODE, 4'h0);
    $display("test event mode done");
  endtask

  // with ce_in low neither a write nor an underflow may change state
  task automatic test_hold();
    @(posedge ref_clk_in);
    ce <= 1'b0;
    uf1 <= 1'b1;
    req <= '{addr: ADDR_CLK_SRC, wdata: 4'h3, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk_in);
    ce <= 1'b1;
    uf1 <= 1'b0;
    req <= '0;
    #1 chk(16'(fl1), 16'h0000);
    rd_chk(ADDR_CLK_SRC, 4'h0);
    $display("test clock enable hold done");
  endtask

  // misc bits: noise reject, polarity, tone enable, tone channel, runs 0/1, reloads 0/1
  task automatic test_outputs();
    wr(ADDR_T0_MODE, 4'h3);
    wr(ADDR_CLK_SRC, 4'hc);
    wr(ADDR_T0_CTRL, 4'h3);
    #1 chk(16'(misc), 16'h005f);
    wr(ADDR_T1_CTRL, 4'h3);
    #1 chk(16'(misc), 16'h00bf);
    rd_chk(ADDR_T0_MODE, 4'h3);
    wr(ADDR_T0_CTRL, 4'h0);
    wr(ADDR_T1_CTRL, 4'h0);
    wr(ADDR_T0_MODE, 4'h0);
    wr(ADDR_CLK_SRC, 4'h0);
    #1 chk(16'(misc), 16'h0000);
    $display("test side outputs done");
  endtask

  // a reset in mid-run must bring back every reset value, flags included
  task automatic test_mid_reset();
    wr(ADDR_T0_MODE, 4'h4);
    wr(ADDR_CLK_SRC, 4'h3);
    wr(ADDR_T1_CTRL, 4'hc);
    pulse(3);
    pulse(4);
    #1 chk(16'({fl1, fl0}), 16'h0003);
    @(posedge ref_clk_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    #1 chk(16'({evsel, fl1, fl0}), 16'h0000);
    test_reset();
    $display("test mid-run reset done");
  endtask

  initial begin
    #400000;
    fail_count++;
    report_and_stop();
  end

  initial begin
    repeat (20) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    test_reset();
    test_flags();
    test_hold();
    test_outputs();
    for (int r = 0; r < 4; r++) begin
      run_ratio(0, 2'(r), 0);
      run_ratio(1, 2'(r), 1);
    end
    run_ratio(0, 2'h1, 1);
    run_ratio(1, 2'h1, 0);
    test_event();
    test_mid_reset();
    report_and_stop();
  end
endmodule
